// ===== verilog/qpv_map.vh
// Register map, field positions and reset values of the encoder interface
// What this block does
// - Velocity runs only with position tracking enabled
// - Swap option exchanges channels before decoding
// - Clock/direction mode: step clock plus direction
// - Capture select: A edges only, or both
// - A leading B increments position per edge
// - B leading A decrements position per edge
// - Same channel toggling twice flags direction change
// - Reload select 1: index clears position
// - Backward step from zero loads max_position
// - Reload select 0: index ignored, range 0..max
// - Non-index mode wraps after reaching max_position
// - Velocity counts same selected edges into edge_count
// - Timer counts down, expires, reloads, continues
// - Events: phase error, direction, index, timer
// - Mask, raw and masked status; irq on any
// - Prescale divides counted edges by 2^code
// - Optional inversion of A, B and index
`ifndef QPV_MAP_VH
`define QPV_MAP_VH

`define QPV_ADDR_W 8
`define QPV_CTL_OFF 8'h00
`define QPV_STAT_OFF 8'h04
`define QPV_POS_OFF 8'h08
`define QPV_MAXPOS_OFF 8'h0C
`define QPV_LOAD_OFF 8'h10
`define QPV_TIME_OFF 8'h14
`define QPV_COUNT_OFF 8'h18
`define QPV_SPEED_OFF 8'h1C
`define QPV_INTEN_OFF 8'h20
`define QPV_RIS_OFF 8'h24
`define QPV_ISC_OFF 8'h28

`define QPV_CTL_W 12
`define QPV_CTL_ENABLE 0
`define QPV_CTL_SWAP 1
`define QPV_CTL_SIGNAL_MODE_SELECT 2
`define QPV_CTL_EDGE_CAPTURE_SELECT 3
`define QPV_CTL_COUNTER_RELOAD_SELECT 4
`define QPV_CTL_VELEN 5
`define QPV_CTL_DIV_LO 6
`define QPV_CTL_DIV_HI 8
`define QPV_CTL_INVERT_CHANNEL_A 9
`define QPV_CTL_INVERT_CHANNEL_B 10
`define QPV_CTL_INVERT_INDEX 11

`define QPV_STAT_BACKWARD 0
`define QPV_STAT_INDEX_SEEN 1

`define QPV_INT_W 4
`define QPV_INT_INDEX 0
`define QPV_INT_TIMER 1
`define QPV_INT_DIR 2
`define QPV_INT_ERROR 3

`define QPV_CTL_RST 12'h000
`define QPV_WORD_RST 32'h00000000
`define QPV_INT_RST 4'h0

`endif

// ===== verilog/qpv_sync.v
// Two-stage synchroniser for the encoder pins
`timescale 1ns/1ps
`default_nettype none
module qpv_sync #(
	parameter W = 3
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

reg [W-1:0] meta_q;

// First stage feeds only the second
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		meta_q <= {W{1'b0}};
		q <= {W{1'b0}};
	end else begin
		meta_q <= d;
		q <= meta_q;
	end
end

endmodule // qpv_sync
`default_nettype wire

// ===== verilog/qpv_velocity.v
// Velocity capture: edge prescaler, interval timer and edge counters
`timescale 1ns/1ps
`default_nettype none
module qpv_velocity #(
	parameter W = 32
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire edge_in,
	input wire [2:0] prescale,
	input wire [W-1:0] load,
	output reg [W-1:0] timer_q,
	output reg [W-1:0] count_q,
	output reg [W-1:0] speed_q,
	output reg expire_q
);

reg [6:0] pre_q;
wire [6:0] pre_lim;
wire pass;

assign pre_lim = (7'h01 << prescale) - 7'h01;
assign pass = edge_in & (pre_q == pre_lim);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		pre_q <= 7'h00;
		timer_q <= {W{1'b0}};
		count_q <= {W{1'b0}};
		speed_q <= {W{1'b0}};
		expire_q <= 1'b0;
	end else begin
		expire_q <= 1'b0;
		if (!run) begin
			// Idle: armed so the first interval is a full one
			pre_q <= 7'h00;
			timer_q <= load;
			count_q <= {W{1'b0}};
		end else begin
			if (edge_in)
				pre_q <= pass ? 7'h00 : pre_q + 7'h01;
			if (timer_q == {W{1'b0}}) begin
				expire_q <= 1'b1;
				timer_q <= load;
				speed_q <= count_q;
				// An edge in the closing cycle opens the new count
				count_q <= {{(W-1){1'b0}}, pass};
			end else begin
				timer_q <= timer_q - {{(W-1){1'b0}}, 1'b1};
				if (pass)
					count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
end

endmodule // qpv_velocity
`default_nettype wire

// ===== verilog/qpv_encoder_interface.v
// Encoder interface top: APB registers, decoder, position and events
`timescale 1ns/1ps
`default_nettype none
`include "qpv_map.vh"
module qpv_encoder_interface #(
	parameter POS_W = 32
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`QPV_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire quad_channel_a_pin,
	input wire quad_channel_b_pin,
	input wire index_input_pin,
	output reg encoder_irq
);

////////////////////////////////////////////////////////////////////////////
// Functions

// Next position for one step with wrap at both ends
function [POS_W-1:0] step_pos;
	input [POS_W-1:0] pos;
	input [POS_W-1:0] max;
	input up;
	begin
		if (up) begin
			if (pos >= max)
				step_pos = {POS_W{1'b0}};
			else
				step_pos = pos + {{(POS_W-1){1'b0}}, 1'b1};
		end else begin
			if (pos == {POS_W{1'b0}})
				step_pos = max;
			else
				step_pos = pos - {{(POS_W-1){1'b0}}, 1'b1};
		end
	end
endfunction

// One register write strobe: the access edge and a matching offset
function wr_hit;
	input [`QPV_ADDR_W-1:0] addr;
	input [`QPV_ADDR_W-1:0] off;
	input wr;
	begin
		wr_hit = wr & (addr == off);
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Declarations

reg [`QPV_CTL_W-1:0] ctl_q;
reg [POS_W-1:0] pos_q;
reg [POS_W-1:0] pos_d;
reg [POS_W-1:0] maxpos_q;
reg [31:0] load_q;
reg [`QPV_INT_W-1:0] inten_q;
reg [`QPV_INT_W-1:0] ris_q;
reg [`QPV_INT_W-1:0] ris_d;
reg a_prev_q;
reg b_prev_q;
reg i_prev_q;
reg last_a_q;
reg last_valid_q;
reg dir_back_q;
reg index_seen_q;
reg [31:0] rd_mux;
reg rd_hit;

wire [2:0] pins_sync;
wire access;
wire fire;
wire wr_fire;
// Write strobes
wire wr_ctl;
wire wr_pos;
wire wr_max;
wire wr_load;
wire wr_inten;
wire wr_isc;
wire en;
wire vel_run;
wire a_inv;
wire b_inv;
wire i_inv;
wire a_ph;
wire b_ph;
wire ea;
wire eb;
wire idx_rise;
wire q_err;
wire q_up;
wire q_step;
wire q_rev;
wire c_step;
wire c_up;
wire c_rev;
wire step;
wire step_up;
wire dir_chg;
wire phase_err;
wire [`QPV_INT_W-1:0] events;
// Event sources
wire ev_index;
wire ev_timer;
wire ev_dir;
wire ev_err;
wire [31:0] timer_w;
wire [31:0] count_w;
wire [31:0] speed_w;
wire expire_w;

////////////////////////////////////////////////////////////////////////////
// Input conditioning

// Pins are asynchronous to pclk
qpv_sync #(
	.W(3)
) u_sync (
	.clk(pclk),
	.rst_n(presetn),
	.d({index_input_pin, quad_channel_b_pin, quad_channel_a_pin}),
	.q(pins_sync)
);

assign en = ctl_q[`QPV_CTL_ENABLE];
assign vel_run = en & ctl_q[`QPV_CTL_VELEN];

assign a_inv = pins_sync[0] ^ ctl_q[`QPV_CTL_INVERT_CHANNEL_A];
assign b_inv = pins_sync[1] ^ ctl_q[`QPV_CTL_INVERT_CHANNEL_B];
assign i_inv = pins_sync[2] ^ ctl_q[`QPV_CTL_INVERT_INDEX];

assign a_ph = ctl_q[`QPV_CTL_SWAP] ? b_inv : a_inv;
assign b_ph = ctl_q[`QPV_CTL_SWAP] ? a_inv : b_inv;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		a_prev_q <= 1'b0;
		b_prev_q <= 1'b0;
		i_prev_q <= 1'b0;
	end else begin
		a_prev_q <= a_ph;
		b_prev_q <= b_ph;
		i_prev_q <= i_inv;
	end
end

assign ea = a_ph ^ a_prev_q;
assign eb = b_ph ^ b_prev_q;
assign idx_rise = i_inv & ~i_prev_q;

////////////////////////////////////////////////////////////////////////////
// Decoder

// Quadrature: both phases moving at once cannot be ordered
assign q_err = ea & eb;
// A edge with A != B, or B edge with A == B, means A leads
assign q_up = ea ? (a_ph ^ b_ph) : ~(a_ph ^ b_ph);
assign q_step = ~q_err & (ea | (ctl_q[`QPV_CTL_EDGE_CAPTURE_SELECT] & eb));
// Two edges in a row on one channel: rotation reversed
assign q_rev = last_valid_q & ~q_err &
	((ea & last_a_q) | (eb & ~last_a_q));

// Clock/direction: A rising is a step, B low means forward
assign c_step = a_ph & ~a_prev_q;
assign c_up = ~b_ph;
assign c_rev = c_step & (c_up == dir_back_q);

assign step = en & (ctl_q[`QPV_CTL_SIGNAL_MODE_SELECT] ? c_step : q_step);
assign step_up = ctl_q[`QPV_CTL_SIGNAL_MODE_SELECT] ? c_up : q_up;
assign dir_chg = en & (ctl_q[`QPV_CTL_SIGNAL_MODE_SELECT] ? c_rev : q_rev);
assign phase_err = en & ~ctl_q[`QPV_CTL_SIGNAL_MODE_SELECT] & q_err;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		last_a_q <= 1'b0;
		last_valid_q <= 1'b0;
		dir_back_q <= 1'b0;
	end else if (!en) begin
		last_valid_q <= 1'b0;
	end else begin
		if (!ctl_q[`QPV_CTL_SIGNAL_MODE_SELECT] && (ea ^ eb)) begin
			last_a_q <= ea;
			last_valid_q <= 1'b1;
		end
		if (step)
			dir_back_q <= ~step_up;
	end
end

////////////////////////////////////////////////////////////////////////////
// Position counter

// Software write wins over index and step
always @* begin
	pos_d = pos_q;
	if (wr_pos)
		pos_d = pwdata[POS_W-1:0];
	else if (en && ctl_q[`QPV_CTL_COUNTER_RELOAD_SELECT] && idx_rise)
		pos_d = {POS_W{1'b0}};
	else if (step)
		// Wraps to zero past max, to max below zero
		pos_d = step_pos(pos_q, maxpos_q, step_up);
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pos_q <= {POS_W{1'b0}};
		index_seen_q <= 1'b0;
	end else begin
		pos_q <= pos_d;
		if (ev_index)
			index_seen_q <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////
// Velocity capture

qpv_velocity #(
	.W(32)
) u_vel (
	.clk(pclk),
	.rst_n(presetn),
	.run(vel_run),
	.edge_in(step),
	.prescale(ctl_q[`QPV_CTL_DIV_HI:`QPV_CTL_DIV_LO]),
	.load(load_q),
	.timer_q(timer_w),
	.count_q(count_w),
	.speed_q(speed_w),
	.expire_q(expire_w)
);

////////////////////////////////////////////////////////////////////////////
// Events and interrupt

// Events only count while the decoder is enabled
assign ev_index = en & idx_rise;
assign ev_timer = expire_w;
assign ev_dir = dir_chg;
assign ev_err = phase_err;
assign events = {ev_err, ev_dir, ev_timer, ev_index};

always @* begin
	ris_d = ris_q;
	if (wr_isc)
		ris_d = ris_q & ~pwdata[`QPV_INT_W-1:0];
	// New event beats a clear in the same cycle
	ris_d = ris_d | events;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ris_q <= `QPV_INT_RST;
		encoder_irq <= 1'b0;
	end else begin
		ris_q <= ris_d;
		encoder_irq <= |(ris_q & inten_q);
	end
end

////////////////////////////////////////////////////////////////////////////
// APB slave

assign access = psel & penable;
assign fire = access & pready;
assign wr_fire = fire & pwrite;

////////////////////////////////////////////////////////////////////////////
// Register write strobes

// Decoded once, so every register sees the same edge
assign wr_ctl = wr_hit(paddr, `QPV_CTL_OFF, wr_fire);
assign wr_pos = wr_hit(paddr, `QPV_POS_OFF, wr_fire);
assign wr_max = wr_hit(paddr, `QPV_MAXPOS_OFF, wr_fire);
assign wr_load = wr_hit(paddr, `QPV_LOAD_OFF, wr_fire);
assign wr_inten = wr_hit(paddr, `QPV_INTEN_OFF, wr_fire);
assign wr_isc = wr_hit(paddr, `QPV_ISC_OFF, wr_fire);

always @* begin
	rd_mux = `QPV_WORD_RST;
	rd_hit = 1'b1;
	case (paddr)
	`QPV_CTL_OFF: rd_mux[`QPV_CTL_W-1:0] = ctl_q;
	`QPV_STAT_OFF: begin
		rd_mux[`QPV_STAT_BACKWARD] = dir_back_q;
		rd_mux[`QPV_STAT_INDEX_SEEN] = index_seen_q;
	end
	`QPV_POS_OFF: rd_mux[POS_W-1:0] = pos_q;
	`QPV_MAXPOS_OFF: rd_mux[POS_W-1:0] = maxpos_q;
	`QPV_LOAD_OFF: rd_mux = load_q;
	`QPV_TIME_OFF: rd_mux = timer_w;
	`QPV_COUNT_OFF: rd_mux = count_w;
	`QPV_SPEED_OFF: rd_mux = speed_w;
	`QPV_INTEN_OFF: rd_mux[`QPV_INT_W-1:0] = inten_q;
	`QPV_RIS_OFF: rd_mux[`QPV_INT_W-1:0] = ris_q;
	`QPV_ISC_OFF: rd_mux[`QPV_INT_W-1:0] = ris_q & inten_q;
	default: rd_hit = 1'b0;
	endcase
end

// One wait state: data is latched the cycle before it is sampled
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		prdata <= `QPV_WORD_RST;
		pslverr <= 1'b0;
	end else begin
		pready <= access & ~pready;
		if (access && !pready) begin
			prdata <= pwrite ? `QPV_WORD_RST : rd_mux;
			pslverr <= ~rd_hit;
		end else begin
			prdata <= `QPV_WORD_RST;
			pslverr <= 1'b0;
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctl_q <= `QPV_CTL_RST;
		maxpos_q <= {POS_W{1'b0}};
		load_q <= `QPV_WORD_RST;
		inten_q <= `QPV_INT_RST;
	end else begin
		if (wr_ctl)
			ctl_q <= pwdata[`QPV_CTL_W-1:0];
		if (wr_max)
			maxpos_q <= pwdata[POS_W-1:0];
		if (wr_load)
			load_q <= pwdata;
		if (wr_inten)
			inten_q <= pwdata[`QPV_INT_W-1:0];
	end
end

endmodule // qpv_encoder_interface
`default_nettype wire

// ===== bench/qpv_monitor.sv
// Checker of bus timing and interrupt masking
`timescale 1ns/1ps
`default_nettype none
module qpv_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic encoder_irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	////////////////////////////////
	// Software polls status, so a lost wait state corrupts reads
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	a_one_wait: assert property ($rose(penable) && psel |-> s_one_wait)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_ready: assert property (pslverr |-> acc)
		else $error("error outside access");
	a_unmapped_err: assert property (acc && paddr > 8'h28 |-> pslverr)
		else $error("unmapped offset accepted");
	a_mapped_ok: assert property (
		acc && paddr < 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped offset refused");
	a_mask_off_irq: assert property (
		acc && pwrite && paddr == 8'h20 && pwdata[3:0] == 4'h0
		|-> ##2 !encoder_irq)
		else $error("irq with all masks off");
	a_irq_reset: assert property ($rose(presetn) |-> !encoder_irq)
		else $error("irq high after reset");
endmodule // qpv_monitor
bind qpv_encoder_interface qpv_monitor qpv_monitor_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .encoder_irq(encoder_irq));
`default_nettype wire

// ===== bench/qpv_encoder_model.sv
// Behavioural encoder driving phase and index pins
`timescale 1ns/1ps
`default_nettype none
module qpv_encoder_model (
	input wire logic pclk,
	input wire logic [1:0] mv,
	input wire logic idx,
	output logic quad_channel_a_pin,
	output logic quad_channel_b_pin,
	output logic index_input_pin
);
	logic [1:0] c_q = 2'h0;
	////////////////////////////////
	// Step 1 forward, 3 backward, 2 both phases at once
	always @(posedge pclk) begin
		c_q <= c_q + mv;
	end
	// Gray order, A leads B going forward
	assign quad_channel_a_pin = c_q[1] ^ c_q[0];
	assign quad_channel_b_pin = c_q[1];
	assign index_input_pin = idx;
endmodule // qpv_encoder_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the encoder interface
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic idx = 0;
	logic [1:0] mv = 2'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, irq, a, b, x;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int i;
	int polls;
	always #12.5 pclk = ~pclk;
	qpv_encoder_interface qpv_encoder_interface_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .quad_channel_a_pin(a), .quad_channel_b_pin(b),
		.index_input_pin(x), .encoder_irq(irq));
	qpv_encoder_model qpv_encoder_model_i (.pclk(pclk), .mv(mv), .idx(idx),
		.quad_channel_a_pin(a), .quad_channel_b_pin(b), .index_input_pin(x));
	////////////////////////////////
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			$display("mismatch %0t timeout", $time);
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		apb(0, ad, 0);
		chk(rd, e);
	endtask
	// Seven idle cycles keep edges well under a quarter clock
	task automatic step(input int n, input logic [1:0] k);
		repeat (n) begin
			mv <= k;
			@(posedge pclk);
			mv <= 2'h0;
			repeat (7) @(posedge pclk);
		end
	endtask
	task automatic wait_exp;
		rd = 0;
		polls = 0;
		while (rd[1] !== 1'b1) begin
			apb(0, 8'h24, 0);
			polls++;
		end
	endtask
	task automatic t_regs;
		rc(8'h00, 0);
		apb(1, 8'h14, 32'h5);
		rc(8'h14, 0);
		rc(8'h30, 0);
		chk(er, 1);
		$display("regs done");
	endtask
	task automatic t_quad;
		apb(1, 8'h0C, 100);
		apb(1, 8'h00, 32'h1);
		step(4, 1);
		rc(8'h08, 2);
		apb(1, 8'h00, 32'h9);
		step(4, 1);
		rc(8'h08, 6);
		step(4, 3);
		rc(8'h08, 2);
		rc(8'h04, 32'h1);
		rc(8'h24, 4);
		apb(1, 8'h08, 0);
		step(1, 3);
		rc(8'h08, 100);
		step(1, 1);
		rc(8'h08, 0);
		$display("quad done");
	endtask
	task automatic t_err;
		apb(1, 8'h28, 32'hF);
		apb(1, 8'h20, 32'h8);
		step(2, 2);
		rc(8'h08, 0);
		rc(8'h28, 8);
		chk(irq, 1);
		apb(1, 8'h20, 32'h0);
		@(posedge pclk);
		chk(irq, 0);
		apb(1, 8'h20, 32'h8);
		apb(1, 8'h28, 32'hF);
		rc(8'h28, 0);
		chk(irq, 0);
		$display("error done");
	endtask
	task automatic t_cfg;
		logic [31:0] k[3] = '{32'hB, 32'h209, 32'h409};
		foreach (k[j]) begin
			apb(1, 8'h00, k[j]);
			repeat (6) @(posedge pclk);
			apb(1, 8'h08, 50);
			step(4, 1);
			rc(8'h08, 46);
		end
		apb(1, 8'h00, 32'h5);
		apb(1, 8'h08, 10);
		step(4, 1);
		rc(8'h08, 11);
		step(4, 3);
		rc(8'h08, 10);
		$display("config done");
	endtask
	task automatic t_index;
		for (i = 0; i < 2; i++) begin
			apb(1, 8'h00, i ? 32'h9 : 32'h19);
			apb(1, 8'h08, 7);
			idx <= 1;
			repeat (8) @(posedge pclk);
			idx <= 0;
			repeat (6) @(posedge pclk);
			rc(8'h08, i ? 7 : 0);
		end
		apb(0, 8'h24, 0);
		chk(rd & 32'h1, 1);
		$display("index done");
	endtask
	task automatic t_vel;
		apb(1, 8'h10, 199);
		apb(1, 8'h00, 32'h20);
		repeat (250) @(posedge pclk);
		rc(8'h14, 199);
		for (i = 0; i < 3; i++) begin
			apb(1, 8'h00, 32'h9);
			apb(1, 8'h28, 32'hF);
			apb(1, 8'h00, 32'h29 | (i << 6));
			step(8, 1);
			wait_exp();
			rc(8'h1C, 8 >> i);
			rc(8'h18, 0);
		end
		apb(1, 8'h28, 32'hF);
		wait_exp();
		chk(rd & 32'h2, 2);
		chk(polls <= 51, 1);
		rc(8'h1C, 0);
		$display("velocity done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_quad();
		t_err();
		t_cfg();
		t_index();
		t_vel();
		give_verdict();
	end
endmodule // tb
`default_nettype wire
